// [logic/fspp_pkg.sv]
// Shared constants and carrier types for the filter serial programming port
package fspp_pkg;

    // Serial word layout
    localparam int WORD_BITS = 8;
    localparam int DATA_BITS = 6;
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 6;

    // Register addresses carried in the two top word bits
    localparam logic [1:0] ADDR_CUTOFF_A = 2'h0;
    localparam logic [1:0] ADDR_CUTOFF_B = 2'h1;
    localparam logic [1:0] ADDR_UNMAPPED = 2'h2;
    localparam logic [1:0] ADDR_GAIN = 2'h3;

    // Cutoff register A fields
    localparam int A_STEP_MSB = 5;
    localparam int A_STEP_LSB = 3;
    localparam int A_CHORD_MSB = 2;
    localparam int A_CHORD_LSB = 0;

    // Cutoff register B fields
    localparam int B_OSC_BIT = 5;
    localparam int B_ZERO_BIT = 4;
    localparam int B_STEP_MSB = 3;
    localparam int B_STEP_LSB = 0;

    // Reset value of every setting register
    localparam logic [5:0] SETTING_RESET = 6'h00;

    // Cutoff arithmetic in units of 0.25 kHz: lowest octave 0.8 MHz, 6.25 kHz steps
    localparam logic [16:0] FMIN_QKHZ = 17'h00C80;
    localparam logic [16:0] FSTEP_QKHZ = 17'h00019;
    localparam int OCTAVES = 5;

    // Gain arithmetic in units of 0.5 dB: coarse 18 dB minus 3 dB per code
    localparam logic [6:0] COARSE_TOP_HDB = 7'h24;
    localparam logic [6:0] COARSE_STEP_HDB = 7'h06;
    localparam logic [2:0] FINE_TOP_HDB = 3'h5;
    localparam logic [2:0] FINE_ZERO_CODE = 3'h5;

    // Settings as held by the three registers
    typedef struct packed {
        logic oscillatorTestEnable;
        logic [6:0] cutoffStepCode;
        logic [2:0] octaveChordCode;
        logic [5:0] gainCode;
    } fspp_settings_t;

    // Settings decoded for the analog side
    typedef struct packed {
        logic [4:0] octaveSelect;
        logic [6:0] stepNumber;
        logic [16:0] cutoffQuarterKhz;
        logic [6:0] gainHalfDb;
    } fspp_decoded_t;

endpackage : fspp_pkg

// [logic/fspp_serial_program_port.sv]
// Top of the three-wire filter programming port: shift, cross, load, decode
`timescale 1ns/100ps
`default_nettype none

// How it works
// (R1) Shift serial data into eight-bit register
// (R2) Data sampled on rising shift clock
// (R3) Shift only while load enable high
// (R4) Host writes all registers after power up
// (R5) Three setting registers: gain, cutoff A, B
// (R6) Top two bits address: 00 A, 01 B, 11 gain
// (R7) A holds step bits 2..0, chord code
// (R8) B holds oscillator test, zero, step 6..3
// (R9) Oscillator test enable active high
// (R10) Gain register takes six gain bits in order
// (R11) Chord 000..011 low octaves, 1xx top octave
// (R12) Step code is linear step 0 to 127
// (R13) Low gain bits: 18 dB down to -3 dB
// (R14) High gain bits add 2.5 dB down to 0
// (R15) Word arrives most significant bit first
// (R16) Register updates on load enable falling edge
// (R17) Address 10 updates no register
module fspp_serial_program_port (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic shiftClk,
    input wire logic serialInLine,
    input wire logic loadEnablePin,
    output fspp_pkg::fspp_settings_t settings,
    output fspp_pkg::fspp_decoded_t decoded,
    output logic wordLoaded,
    output logic unmatchedWord,
    output logic reservedBitSet,
    output logic [1:0] lastAddress,
    output logic allProgrammed
);

    // Serial word as built in the shift clock domain
    logic [fspp_pkg::WORD_BITS-1:0] shiftWord;

    // Load enable crossing into the system clock domain
    logic enSync1_reg;
    logic enSync2_reg;
    logic enPrev_reg;
    logic frameEnd;

    // Word crossing; it is stable for the whole tail of a frame
    logic [fspp_pkg::WORD_BITS-1:0] wordSync1_reg;
    logic [fspp_pkg::WORD_BITS-1:0] wordSync2_reg;
    logic [1:0] wordAddress;
    logic [fspp_pkg::DATA_BITS-1:0] wordData;

    // The three setting registers
    logic [fspp_pkg::DATA_BITS-1:0] cutoffChordAndLowStep_reg;
    logic [fspp_pkg::DATA_BITS-1:0] cutoffHighStepAndOsc_reg;
    logic [fspp_pkg::DATA_BITS-1:0] gainSetting_reg;

    // Which registers have been written since reset
    logic [2:0] programmed_reg;
    logic [2:0] programmed_next;

    // Shift register on the link clock
    // Its reset is released while the link clock stands still
    fspp_serial_shifter #(
        .WORD_BITS(fspp_pkg::WORD_BITS)
    ) u_shifter (
        .shiftClk(shiftClk),
        .rst_b(rst_b),
        .serialInLine(serialInLine),
        .loadEnablePin(loadEnablePin),
        .shiftWord(shiftWord)
    );

    // Two-flop synchroniser for the load enable level
    // Nothing but the second flop reads the first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enSync1_reg <= 1'b0;
            enSync2_reg <= 1'b0;
        end else begin
            enSync1_reg <= loadEnablePin;
            enSync2_reg <= enSync1_reg;
        end
    end

    // Edge history taken from the second flop only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enPrev_reg <= 1'b0;
        end else begin
            enPrev_reg <= enSync2_reg;
        end
    end

    // Falling edge of the enable ends the frame; the shift clock may be stopped
    // by then, so the load happens here and not in the link domain
    assign frameEnd = enPrev_reg && !enSync2_reg; // R16

    // Word resampled through two flops; the shifter has not moved for at
    // least the enable hold time before the enable falls, so the copy is whole
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wordSync1_reg <= '0;
            wordSync2_reg <= '0;
        end else begin
            wordSync1_reg <= shiftWord;
            wordSync2_reg <= wordSync1_reg;
        end
    end

    // First bits in are the address; the remainder is data
    // A short frame leaves older bits at the top; the host owns that
    assign wordAddress = wordSync2_reg[fspp_pkg::ADDR_MSB:fspp_pkg::ADDR_LSB]; // R6 R15
    assign wordData = wordSync2_reg[fspp_pkg::DATA_BITS-1:0];

    // Cutoff register A: step bits 2..0 above chord code
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cutoffChordAndLowStep_reg <= fspp_pkg::SETTING_RESET;
        end else if (frameEnd && wordAddress == fspp_pkg::ADDR_CUTOFF_A) begin
            cutoffChordAndLowStep_reg <= wordData; // R5 R6 R7 R16
        end
    end

    // Cutoff register B: oscillator test, a zero bit, step bits 6..3
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cutoffHighStepAndOsc_reg <= fspp_pkg::SETTING_RESET;
        end else if (frameEnd && wordAddress == fspp_pkg::ADDR_CUTOFF_B) begin
            cutoffHighStepAndOsc_reg <= wordData; // R5 R6 R8 R16
        end
    end

    // Gain register: six gain bits MSB to LSB
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gainSetting_reg <= fspp_pkg::SETTING_RESET;
        end else if (frameEnd && wordAddress == fspp_pkg::ADDR_GAIN) begin
            gainSetting_reg <= wordData; // R5 R6 R10 R16
        end
    end

    // Track programming so software sees when all three are set
    // The unmapped arm keeps the case complete
    always_comb begin
        programmed_next = programmed_reg;
        if (frameEnd) begin
            unique case (wordAddress)
                fspp_pkg::ADDR_CUTOFF_A: programmed_next[0] = 1'b1;
                fspp_pkg::ADDR_CUTOFF_B: programmed_next[1] = 1'b1;
                fspp_pkg::ADDR_GAIN: programmed_next[2] = 1'b1;
                fspp_pkg::ADDR_UNMAPPED: programmed_next = programmed_reg; // R17
            endcase
        end
    end

    // Reset clears the record: the analog side holds no defined value until written
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            programmed_reg <= 3'h0;
        end else begin
            programmed_reg <= programmed_next;
        end
    end

    // Flag rises with the load of the last missing register
    // A courtesy flag only; the device itself has no power-on reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            allProgrammed <= 1'b0;
        end else begin
            allProgrammed <= &programmed_next; // R5
        end
    end

    // Load pulse, one cycle, for every mapped word
    // Registered so the pulse lines carry no decode glitches
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wordLoaded <= 1'b0;
        end else begin
            wordLoaded <= frameEnd && wordAddress != fspp_pkg::ADDR_UNMAPPED; // R16
        end
    end

    // Unmatched pulse for a word that addresses no register
    // Lets a host notice a mistyped address
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            unmatchedWord <= 1'b0;
        end else begin
            unmatchedWord <= frameEnd && wordAddress == fspp_pkg::ADDR_UNMAPPED; // R17
        end
    end

    // Bit 4 of a word 01 is stored anyway; flagging is cheaper than refusing it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reservedBitSet <= 1'b0;
        end else begin
            reservedBitSet <= frameEnd && wordAddress == fspp_pkg::ADDR_CUTOFF_B
                && wordData[fspp_pkg::B_ZERO_BIT]; // R8
        end
    end

    // Address of the most recent frame, unmapped ones included
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lastAddress <= 2'h0;
        end else if (frameEnd) begin
            lastAddress <= wordAddress;
        end
    end

    // Settings are plain fields of the three registers
    // One assignment keeps the struct to a single driver
    assign settings = {
        cutoffHighStepAndOsc_reg[fspp_pkg::B_OSC_BIT], // R9
        cutoffHighStepAndOsc_reg[fspp_pkg::B_STEP_MSB:fspp_pkg::B_STEP_LSB], // R8
        cutoffChordAndLowStep_reg[fspp_pkg::A_STEP_MSB:fspp_pkg::A_STEP_LSB], // R7
        cutoffChordAndLowStep_reg[fspp_pkg::A_CHORD_MSB:fspp_pkg::A_CHORD_LSB], // R7
        gainSetting_reg // R10
    };

    // Decoded values one cycle behind the settings
    fspp_setting_decoder u_decoder (
        .clk(clk),
        .rst_b(rst_b),
        .settings(settings),
        .decoded(decoded)
    );

    // Checks on load timing and field placement

    a_load_cutoff_a: assert property (@(posedge clk) disable iff (!rst_b)
        frameEnd && wordAddress == fspp_pkg::ADDR_CUTOFF_A
        |=> settings.octaveChordCode == $past(wordSync2_reg[2:0])
            && settings.cutoffStepCode[2:0] == $past(wordSync2_reg[5:3]))
        else $error("word 00 did not land in cutoff register A fields"); // R7

    a_load_cutoff_b: assert property (@(posedge clk) disable iff (!rst_b)
        frameEnd && wordAddress == fspp_pkg::ADDR_CUTOFF_B
        |=> settings.cutoffStepCode[6:3] == $past(wordSync2_reg[3:0])
            && settings.oscillatorTestEnable == $past(wordSync2_reg[5]))
        else $error("word 01 did not land in cutoff register B fields"); // R8

    a_osc_active_high: assert property (@(posedge clk) disable iff (!rst_b)
        frameEnd && wordAddress == fspp_pkg::ADDR_CUTOFF_B && wordSync2_reg[5]
        |=> settings.oscillatorTestEnable ##1 settings.oscillatorTestEnable)
        else $error("a set test bit did not enable the oscillator"); // R9

    a_load_gain: assert property (@(posedge clk) disable iff (!rst_b)
        frameEnd && wordAddress == fspp_pkg::ADDR_GAIN
        |=> settings.gainCode == $past(wordSync2_reg[5:0]))
        else $error("word 11 did not land in the gain register"); // R10

    a_no_early_load: assert property (@(posedge clk) disable iff (!rst_b)
        !frameEnd |=> $stable(settings))
        else $error("a setting changed without a load enable falling edge"); // R16

    a_unmapped_ignored: assert property (@(posedge clk) disable iff (!rst_b)
        frameEnd && wordAddress == fspp_pkg::ADDR_UNMAPPED
        |=> $stable(settings) && unmatchedWord && !wordLoaded)
        else $error("address 10 changed a register or was not flagged"); // R17

    a_only_addressed: assert property (@(posedge clk) disable iff (!rst_b)
        frameEnd && wordAddress == fspp_pkg::ADDR_GAIN
        |=> $stable(settings.cutoffStepCode) && $stable(settings.octaveChordCode))
        else $error("a gain word disturbed the cutoff registers"); // R6

    a_fall_to_load: assert property (@(posedge clk) disable iff (!rst_b)
        enSync2_reg ##1 !enSync2_reg && wordAddress != fspp_pkg::ADDR_UNMAPPED
        |=> wordLoaded ##1 !wordLoaded)
        else $error("frame end did not give exactly one load pulse"); // R16

    a_all_three: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(allProgrammed) |-> wordLoaded && programmed_reg == 3'h7)
        else $error("all-programmed flag rose without a completing load"); // R5

    // Checks on register isolation, status and the word crossing
    // Three of these fire only if a load leaks into a neighbour

    a_cutoff_a_kept: assert property (@(posedge clk) disable iff (!rst_b)
        frameEnd && wordAddress == fspp_pkg::ADDR_CUTOFF_B
        |=> $stable(settings.octaveChordCode) && $stable(settings.cutoffStepCode[2:0]))
        else $error("a word 01 disturbed cutoff register A"); // R6

    a_cutoff_b_kept: assert property (@(posedge clk) disable iff (!rst_b)
        frameEnd && wordAddress == fspp_pkg::ADDR_CUTOFF_A
        |=> $stable(settings.oscillatorTestEnable) && $stable(settings.cutoffStepCode[6:3]))
        else $error("a word 00 disturbed cutoff register B"); // R6

    a_gain_isolated: assert property (@(posedge clk) disable iff (!rst_b)
        frameEnd && wordAddress != fspp_pkg::ADDR_GAIN |=> $stable(settings.gainCode))
        else $error("a word not addressed to gain changed the gain"); // R6

    a_last_address: assert property (@(posedge clk) disable iff (!rst_b)
        frameEnd |=> lastAddress == $past(wordAddress))
        else $error("last address does not show the frame just ended"); // R6

    a_reserved_flag: assert property (@(posedge clk) disable iff (!rst_b)
        reservedBitSet |-> wordLoaded && lastAddress == fspp_pkg::ADDR_CUTOFF_B
            && cutoffHighStepAndOsc_reg[fspp_pkg::B_ZERO_BIT])
        else $error("reserved flag without a stored word 01 carrying bit 4"); // R8

    a_pulse_exclusive: assert property (@(posedge clk) disable iff (!rst_b)
        !(wordLoaded && unmatchedWord))
        else $error("one frame reported as both loaded and unmatched"); // R17

    a_pulse_single: assert property (@(posedge clk) disable iff (!rst_b)
        wordLoaded |=> !wordLoaded)
        else $error("load pulse lasted more than one cycle"); // R16

    a_programmed_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        allProgrammed |=> allProgrammed)
        else $error("all-programmed flag fell without a reset"); // R5

    // The crossing relies on the word having settled before the enable falls
    a_word_settled: assert property (@(posedge clk) disable iff (!rst_b)
        frameEnd |-> $stable(wordSync2_reg))
        else $error("word copy still moving when the frame ended"); // R16

    // Main scenarios

    c_load_a: cover property (@(posedge clk) disable iff (!rst_b)
        frameEnd && wordAddress == fspp_pkg::ADDR_CUTOFF_A);

    c_load_b_osc: cover property (@(posedge clk) disable iff (!rst_b)
        frameEnd && wordAddress == fspp_pkg::ADDR_CUTOFF_B && wordData[fspp_pkg::B_OSC_BIT]);

    c_load_gain: cover property (@(posedge clk) disable iff (!rst_b)
        frameEnd && wordAddress == fspp_pkg::ADDR_GAIN);

    c_unmapped: cover property (@(posedge clk) disable iff (!rst_b)
        frameEnd && wordAddress == fspp_pkg::ADDR_UNMAPPED);

    c_all_programmed: cover property (@(posedge clk) disable iff (!rst_b)
        $rose(allProgrammed));

endmodule : fspp_serial_program_port

`default_nettype wire

// [logic/fspp_serial_shifter.sv]
// Shift register running on the serial shift clock
`timescale 1ns/100ps
`default_nettype none

module fspp_serial_shifter #(
    parameter int WORD_BITS = fspp_pkg::WORD_BITS
) (
    input wire logic shiftClk,
    input wire logic rst_b,
    input wire logic serialInLine,
    input wire logic loadEnablePin,
    output logic [WORD_BITS-1:0] shiftWord
);

    // Address decode needs the two top bits above at least one data bit
    if (WORD_BITS < 3) begin : g_bad_width
        $error("fspp_serial_shifter: WORD_BITS must be at least 3");
    end

    // Shift in MSB first only while the frame is open; last eight bits win
    always_ff @(posedge shiftClk or negedge rst_b) begin
        if (!rst_b) begin
            shiftWord <= '0;
        end else if (loadEnablePin) begin
            shiftWord <= {shiftWord[WORD_BITS-2:0], serialInLine}; // R1 R2 R3 R15
        end
    end

    a_shift_msb_first: assert property (@(posedge shiftClk) disable iff (!rst_b)
        loadEnablePin |=> shiftWord == {$past(shiftWord[WORD_BITS-2:0]), $past(serialInLine)})
        else $error("shift register did not take the data bit at the LSB"); // R1

    a_idle_holds_word: assert property (@(posedge shiftClk) disable iff (!rst_b)
        !loadEnablePin |=> $stable(shiftWord))
        else $error("shift register moved while the load enable was low"); // R3

endmodule : fspp_serial_shifter

`default_nettype wire

// [logic/fspp_setting_decoder.sv]
// Decodes octave chord, step and gain codes into setting values
`timescale 1ns/100ps
`default_nettype none

module fspp_setting_decoder (
    input wire logic clk,
    input wire logic rst_b,
    input wire fspp_pkg::fspp_settings_t settings,
    output fspp_pkg::fspp_decoded_t decoded
);

    logic [2:0] octaveIndex;
    logic [16:0] cutoffBase;
    logic [6:0] coarseHalfDb;
    logic [6:0] fineHalfDb;

    // Any chord code with its top bit set means the top octave
    always_comb begin
        octaveIndex = settings.octaveChordCode[2] ? 3'(fspp_pkg::OCTAVES - 1)
            : {1'b0, settings.octaveChordCode[1:0]}; // R11
        cutoffBase = 17'(fspp_pkg::FMIN_QKHZ + 17'(settings.cutoffStepCode) * fspp_pkg::FSTEP_QKHZ);
        coarseHalfDb = 7'(fspp_pkg::COARSE_TOP_HDB
            - 7'(settings.gainCode[2:0]) * fspp_pkg::COARSE_STEP_HDB); // R13
        fineHalfDb = (settings.gainCode[5:3] >= fspp_pkg::FINE_ZERO_CODE) ? 7'h00
            : 7'(fspp_pkg::FINE_TOP_HDB - settings.gainCode[5:3]); // R14
    end

    // Each octave doubles both minimum and step, so one shift scales both
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            decoded <= '0;
        end else begin
            decoded.octaveSelect <= 5'(5'h01 << octaveIndex); // R11
            decoded.stepNumber <= settings.cutoffStepCode; // R12
            decoded.cutoffQuarterKhz <= 17'(cutoffBase << octaveIndex); // R12
            decoded.gainHalfDb <= 7'(coarseHalfDb + fineHalfDb); // R13 R14
        end
    end

    a_octave_top: assert property (@(posedge clk) disable iff (!rst_b)
        settings.octaveChordCode[2] |=> decoded.octaveSelect == 5'h10)
        else $error("chord code 1xx did not select the top octave"); // R11

    a_cutoff_linear: assert property (@(posedge clk) disable iff (!rst_b)
        1'b1 |=> decoded.cutoffQuarterKhz == 17'((fspp_pkg::FMIN_QKHZ
            + 17'($past(settings.cutoffStepCode)) * fspp_pkg::FSTEP_QKHZ)
            << $clog2(decoded.octaveSelect)))
        else $error("cutoff is not minimum plus step number times step size"); // R12

    a_gain_extremes: assert property (@(posedge clk) disable iff (!rst_b)
        settings.gainCode == 6'h3F |=> decoded.gainHalfDb == 7'h7A)
        else $error("code 111111 did not give -3 dB"); // R13 R14

    a_gain_fine_top: assert property (@(posedge clk) disable iff (!rst_b)
        settings.gainCode == 6'h00 |=> decoded.gainHalfDb == 7'h29)
        else $error("code 000000 did not give 20.5 dB"); // R14

endmodule : fspp_setting_decoder

`default_nettype wire

// [verification/fspp_host_model.sv]
// Behavioural host controller driving the three-wire programming link
`timescale 1ns/100ps
`default_nettype none

module fspp_host_model (
    input wire logic clk,
    input wire logic startReq,
    input wire logic [15:0] frameWord,
    input wire logic [4:0] frameBits,
    input wire logic strayClk,
    output logic busy,
    output logic shiftClk,
    output logic serialInLine,
    output logic loadEnablePin
);
    // One frame per request; link clock stands still outside frames but for one stray edge when strayClk is set
    initial begin
        busy = 1'b0;
        shiftClk = 1'b0;
        serialInLine = 1'b0;
        loadEnablePin = 1'b0;
        forever begin
            @(posedge clk iff startReq);
            busy = 1'b1;
            #7;
            loadEnablePin = 1'b1;
            for (int i = 15; i >= 0; i--) begin
                if (i < int'(frameBits)) begin
                    serialInLine = frameWord[i];
                    #40 shiftClk = 1'b1;
                    #40 shiftClk = 1'b0;
                end
            end
            #40 loadEnablePin = 1'b0;
            // Released data line shows the inverse, not a stale copy
            serialInLine = ~serialInLine;
            // Stray edge with enable low, before the transfer lands
            if (strayClk) begin
                #5 shiftClk = 1'b1;
                #40 shiftClk = 1'b0;
            end
            #100 busy = 1'b0;
        end
    end
endmodule : fspp_host_model
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking testbench for the filter serial programming port
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic clk, rst_b, startReq, strayClk, busy, shiftClk, serialInLine, loadEnablePin;
    logic [15:0] frameWord;
    logic [4:0] frameBits;
    fspp_pkg::fspp_settings_t settings, expS, prevS;
    fspp_pkg::fspp_decoded_t decoded;
    logic wordLoaded, unmatchedWord, reservedBitSet, allProgrammed;
    logic [1:0] lastAddress;
    logic [2:0] chordTab [6];
    int failures, n_checks;

    fspp_serial_program_port i_fspp_serial_program_port (.clk(clk), .rst_b(rst_b),
        .shiftClk(shiftClk), .serialInLine(serialInLine), .loadEnablePin(loadEnablePin),
        .settings(settings), .decoded(decoded), .wordLoaded(wordLoaded),
        .unmatchedWord(unmatchedWord), .reservedBitSet(reservedBitSet),
        .lastAddress(lastAddress), .allProgrammed(allProgrammed));

    fspp_host_model i_fspp_host_model (.clk(clk), .startReq(startReq), .frameWord(frameWord),
        .frameBits(frameBits), .strayClk(strayClk), .busy(busy), .shiftClk(shiftClk),
        .serialInLine(serialInLine), .loadEnablePin(loadEnablePin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Reference decode worked out from the octave and gain tables
    function automatic fspp_pkg::fspp_decoded_t dec(input fspp_pkg::fspp_settings_t s);
        fspp_pkg::fspp_decoded_t d;
        int idx;
        idx = s.octaveChordCode[2] ? 4 : int'(s.octaveChordCode[1:0]);
        d.octaveSelect = 5'h01 << idx;
        d.stepNumber = s.cutoffStepCode;
        d.cutoffQuarterKhz = (17'h00C80 + 17'(s.cutoffStepCode) * 17'h00019) << idx;
        d.gainHalfDb = 7'h24 - 7'h06 * 7'(s.gainCode[2:0]);
        if (s.gainCode[5:3] < 3'h5) d.gainHalfDb = d.gainHalfDb + 7'(3'h5 - s.gainCode[5:3]);
        return d;
    endfunction : dec

    // Sends one frame, updates the expectation and compares the outcome
    task automatic word(input logic [15:0] w, input logic [4:0] n, input logic s);
        int k;
        logic [1:0] a;
        k = 0;
        a = w[7:6];
        while (busy) @(posedge clk);
        @(posedge clk);
        startReq <= 1'b1;
        frameWord <= w;
        frameBits <= n;
        strayClk <= s;
        @(posedge clk);
        startReq <= 1'b0;
        #1;
        while (!(wordLoaded === 1'b1 || unmatchedWord === 1'b1) && k < 400) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk("load pulse seen", 1'b1, k < 400);
        case (a)
            fspp_pkg::ADDR_CUTOFF_A: {expS.cutoffStepCode[2:0], expS.octaveChordCode} = w[5:0];
            fspp_pkg::ADDR_CUTOFF_B: {expS.oscillatorTestEnable, expS.cutoffStepCode[6:3]} =
                {w[5], w[3:0]};
            fspp_pkg::ADDR_GAIN: expS.gainCode = w[5:0];
            default: ;
        endcase
        chk("settings", 64'(expS), 64'(settings));
        chk("wordLoaded", a != 2'h2, wordLoaded);
        chk("unmatchedWord", a == 2'h2, unmatchedWord);
        chk("reservedBitSet", a == 2'h1 && w[4], reservedBitSet);
        chk("lastAddress", a, lastAddress);
        @(posedge clk);
        #1;
        chk("decoded", 64'(dec(expS)), 64'(decoded));
    endtask : word

    // Settings must never move while a frame is still open
    always @(posedge clk) begin
        if (loadEnablePin === 1'b1 && settings !== prevS) begin
            failures++;
            $display("CHECK FAILED settings during frame expected %h seen %h", prevS, settings);
        end
        prevS <= settings;
    end

    // Watchdog sized well past some twenty-five frames of about a microsecond each
    initial begin
        #200000;
        failures++;
        $display("CHECK FAILED watchdog expected done seen hang");
        test_done();
    end

    initial begin
        rst_b = 1'b0;
        startReq = 1'b0;
        strayClk = 1'b0;
        frameWord = 16'h0000;
        frameBits = 5'h08;
        expS = '0;
        chordTab = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
        failures = 0;
        n_checks = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk("allProgrammed at reset", 1'b0, allProgrammed);
        word(16'h0000, 5'h08, 1'b0);
        word(16'h0040, 5'h08, 1'b0);
        word(16'h00C0, 5'h08, 1'b0);
        chk("allProgrammed", 1'b1, allProgrammed);
        $display("test power-up programming done");
        for (int i = 0; i < 6; i++) word({10'h000, 3'(i), chordTab[i]}, 5'h08, 1'b0);
        $display("test octave chords done");
        word(16'h003F, 5'h08, 1'b0);
        word(16'h006F, 5'h08, 1'b0);
        word(16'h0050, 5'h08, 1'b0);
        $display("test cutoff register B done");
        for (int i = 0; i < 8; i++) word({10'h003, 3'(7 - i), 3'(i)}, 5'h08, 1'b0);
        word(16'h00FF, 5'h08, 1'b0);
        $display("test gain codes done");
        word(16'h00BF, 5'h08, 1'b0);
        $display("test unmapped address done");
        word(16'h0341, 5'h0A, 1'b0);
        word(16'h0009, 5'h08, 1'b1);
        // Two-bit frame: residue shows whether the stray edge shifted
        word(16'h0027, 5'h02, 1'b0);
        $display("test framing done");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
